/* File: src/uvr_regs.sv */
/*
 * Vendor register group: event latch, transmit trim, headset key and
 * ID resistor conversion control with completion interrupt.
 * Assumes a ULPI front end that decodes immediate register reads and
 * writes into one-cycle strobes on the core clock; converter and ID
 * float detector are analogue and arrive asynchronously.
 */
`timescale 1ns/10ps
`default_nettype none

module uvr_regs
  import uvr_pkg::*;
#(
  parameter int unsigned CONV_CYC = CONV_CYCLES // Conversion length in cycles
) (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       reg_rd_i,            // Immediate read strobe
  input  wire logic       reg_wr_i,            // Immediate write strobe
  input  wire logic [5:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       id_open_i,           // ID pin floating, async
  input  wire logic [2:0] id_meas_code_i,      // Converter result, async
  input  wire logic       id_open_rise_enable_i,
  input  wire logic       id_open_fall_enable_i,
  input  wire logic       kit_irq_enable_i,    // Twin enable, carkit group
  output logic      [7:0] reg_rdata_o,
  output logic            alt_int_o,
  output logic      [1:0] hs_tx_trim_o,
  output logic            headset_mode_on_o,
  output logic            id_measure_run_o,
  output logic      [2:0] id_resistor_code_o,
  output logic            id_measure_done_o
);

  localparam int unsigned CW = $clog2(CONV_CYC + 1);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (CONV_CYC < 2) begin : g_bad_len
    $error("uvr_regs: CONV_CYC must be at least 2");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0]    rdata;
    logic          alt_int;
    logic [1:0]    trim;
    logic [3:0]    key;
    logic          hs_on;
    logic [2:0]    code;
    logic          done;
    logic          go;
    logic          rsv5;
    logic          irq_en;
    logic          l_float;
    logic          l_conv;
    logic [CW-1:0] cnt;
    logic          fl_s1;
    logic          fl_s2;
    logic          fl_prev;
    logic [1:0]    warm;
    logic [2:0]    mc_s1;
    logic [2:0]    mc_s2;
  } uvr_state_t;

  uvr_state_t q;
  uvr_state_t d;
  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic       float_ev;
  logic       conv_ev;
  logic       finish;
  logic [7:0] conv_byte;

  // Reset release through two flops
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Event terms
  // Edges ignored until pin history has filled after reset, no false edge
  assign float_ev = (q.warm == 2'h3)
                  & ((q.fl_s2 & ~q.fl_prev & id_open_rise_enable_i)
                  | (~q.fl_s2 & q.fl_prev & id_open_fall_enable_i));
  assign finish   = q.go && (q.cnt == CW'(CONV_CYC - 1));
  assign conv_ev  = finish & ~q.done & (q.irq_en | kit_irq_enable_i);
  assign conv_byte = {1'b0, q.irq_en, q.rsv5, q.go, q.done, q.code};

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d = q;
    d.alt_int = 1'b0;
    // Synchronisers, then edge history
    d.fl_s1   = id_open_i;
    d.fl_s2   = q.fl_s1;
    d.fl_prev = q.fl_s2;
    d.warm    = (q.warm == 2'h3) ? q.warm : q.warm + 2'h1;
    d.mc_s1   = id_meas_code_i;
    d.mc_s2   = q.mc_s1;
    // Conversion timer runs only while started
    d.cnt = q.go ? CW'(q.cnt + 1'b1) : '0;
    // Register reads
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_LATCH: begin
          d.rdata = {4'h0, q.l_conv, 2'h0, q.l_float};
          d.l_float = 1'b0;
          d.l_conv  = 1'b0;
        end
        ADDR_TRIM:    d.rdata = {1'b0, q.trim, 5'h00};
        ADDR_HEADSET: d.rdata = {4'h0, q.key};
        ADDR_CONV_WR, ADDR_CONV_SET, ADDR_CONV_CLR: begin
          d.rdata = conv_byte;
          d.done  = 1'b0;
        end
        default:      d.rdata = 8'h00;
      endcase
    end
    // Register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_TRIM:    d.trim = reg_wdata_i[TRIM_LSB +: 2];
        ADDR_HEADSET: d.key  = reg_wdata_i[3:0];
        ADDR_CONV_WR: begin
          d.code   = reg_wdata_i[2:0];
          d.go     = reg_wdata_i[CONV_GO_BIT];
          d.rsv5   = reg_wdata_i[CONV_RSV_BIT];
          d.irq_en = reg_wdata_i[CONV_IRQEN_BIT];
        end
        ADDR_CONV_SET: begin
          d.code   = q.code | reg_wdata_i[2:0];
          d.go     = q.go | reg_wdata_i[CONV_GO_BIT];
          d.rsv5   = q.rsv5 | reg_wdata_i[CONV_RSV_BIT];
          d.irq_en = q.irq_en | reg_wdata_i[CONV_IRQEN_BIT];
        end
        ADDR_CONV_CLR: begin
          d.code   = q.code & ~reg_wdata_i[2:0];
          d.go     = q.go & ~reg_wdata_i[CONV_GO_BIT];
          d.rsv5   = q.rsv5 & ~reg_wdata_i[CONV_RSV_BIT];
          d.irq_en = q.irq_en & ~reg_wdata_i[CONV_IRQEN_BIT];
        end
        default: ;
      endcase
    end
    // Completion wins over any clear in the same cycle
    if (finish) begin
      d.go   = 1'b0;
      d.done = 1'b1;
      d.code = q.mc_s2;
      d.cnt  = '0;
    end
    // Latch sets win over read clear
    if (float_ev) begin
      d.l_float = 1'b1;
    end
    if (conv_ev) begin
      d.l_conv = 1'b1;
    end
    d.alt_int = float_ev | conv_ev;
    d.hs_on   = (d.key == HEADSET_KEY);
  end

  // State register
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign reg_rdata_o        = q.rdata;
  assign alt_int_o          = q.alt_int;
  assign hs_tx_trim_o       = q.trim;
  assign headset_mode_on_o  = q.hs_on;
  assign id_measure_run_o   = q.go;
  assign id_resistor_code_o = q.code;
  assign id_measure_done_o  = q.done;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  a_float_latch_set: assert property (float_ev |=> q.l_float && alt_int_o)
    else $error("float event not latched");
  a_conv_latch_set: assert property (conv_ev |=> q.l_conv && alt_int_o)
    else $error("conversion event not latched");
  a_latch_rd_clear: assert property (
    reg_rd_i && reg_addr_i == ADDR_LATCH && !float_ev && !conv_ev
      |=> !q.l_float && !q.l_conv)
    else $error("latch not cleared on read");
  a_latch_rsv_zero: assert property (
    reg_rd_i && reg_addr_i == ADDR_LATCH
      |=> reg_rdata_o[7:4] == 4'h0 && reg_rdata_o[2:1] == 2'h0
          && reg_rdata_o[LATCH_CONV_BIT] == $past(q.l_conv))
    else $error("latch reserved bits not zero");
  a_trim_write: assert property (
    reg_wr_i && reg_addr_i == ADDR_TRIM
      |=> hs_tx_trim_o == $past(reg_wdata_i[TRIM_LSB +: 2]))
    else $error("trim not written");
  a_headset_key: assert property (
    reg_wr_i && reg_addr_i == ADDR_HEADSET
      |=> headset_mode_on_o == ($past(reg_wdata_i[3:0]) == HEADSET_KEY))
    else $error("headset mode disagrees with key");
  a_conv_finish: assert property (
    finish |=> id_measure_done_o && !id_measure_run_o
               && id_resistor_code_o == $past(q.mc_s2))
    else $error("conversion end not reported");
  a_conv_count: assert property (q.cnt < CW'(CONV_CYC))
    else $error("conversion timer overran");
  a_done_rd_clear: assert property (
    reg_rd_i && reg_addr_i == ADDR_CONV_SET && !finish |=> !id_measure_done_o)
    else $error("done not cleared on read");
  a_conv_set_bits: assert property (
    reg_wr_i && reg_addr_i == ADDR_CONV_SET && reg_wdata_i[CONV_IRQEN_BIT]
      |=> q.irq_en)
    else $error("set address did not set enable");
  a_rsv_read_zero: assert property (
    reg_rd_i && (reg_addr_i == ADDR_TRIM || reg_addr_i == ADDR_CONV_WR)
      |=> reg_rdata_o[7] == 1'b0)
    else $error("reserved bit read nonzero");

  c_conv_irq:   cover property (conv_ev ##1 alt_int_o);
  c_float_rise: cover property (float_ev && q.fl_s2);
  c_headset_on: cover property ($rose(headset_mode_on_o));

endmodule // uvr_regs

`default_nettype wire

/* File: src/uvr_pkg.sv */
/*
 * Constants for the vendor register group of the transceiver: register
 * addresses, field positions, reset values, codes and conversion timing.
 * Assumes a 200 MHz core clock and six-bit immediate register addresses.
 */
`default_nettype none

package uvr_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [5:0] ADDR_LATCH     = 6'h21; // Event latch, read clears
  localparam logic [5:0] ADDR_TRIM      = 6'h31; // Transmit amplitude trim
  localparam logic [5:0] ADDR_HEADSET   = 6'h33; // Headset mode key
  localparam logic [5:0] ADDR_CONV_WR   = 6'h36; // Conversion, load
  localparam logic [5:0] ADDR_CONV_SET  = 6'h37; // Conversion, set bits
  localparam logic [5:0] ADDR_CONV_CLR  = 6'h38; // Conversion, clear bits
  localparam logic [5:0] ADDR_VEND_LO   = 6'h30; // Vendor space start
  localparam logic [5:0] ADDR_VEND_HI   = 6'h3F; // Vendor space end

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned LATCH_FLOAT_BIT = 0;
  localparam int unsigned LATCH_CONV_BIT  = 3;
  localparam int unsigned TRIM_LSB        = 5;
  localparam int unsigned CONV_DONE_BIT   = 3;
  localparam int unsigned CONV_GO_BIT     = 4;
  localparam int unsigned CONV_RSV_BIT    = 5;
  localparam int unsigned CONV_IRQEN_BIT  = 6;

  // ****************************************************************
  // Values and codes
  // ****************************************************************
  localparam logic [3:0] HEADSET_KEY     = 4'hA;  // Exact key 1010
  localparam logic [1:0] TRIM_NOMINAL    = 2'h0;  // Nominal drive
  localparam logic [1:0] TRIM_UP_11P1    = 2'h1;  // Drive up 11.1 percent
  localparam logic [1:0] TRIM_UP_7P4     = 2'h2;  // Drive up 7.4 percent
  localparam logic [1:0] TRIM_UP_3P7     = 2'h3;  // Drive up 3.7 percent
  localparam logic [2:0] RCODE_0_OHM     = 3'h0;
  localparam logic [2:0] RCODE_75_OHM    = 3'h1;
  localparam logic [2:0] RCODE_100K      = 3'h2;
  localparam logic [2:0] RCODE_200K      = 3'h3;
  localparam logic [2:0] RCODE_440K      = 3'h4;
  localparam logic [2:0] RCODE_FLOATING  = 3'h5;
  localparam logic [2:0] RCODE_ERROR     = 3'h7;
  localparam logic [7:0] RST_BYTE        = 8'h00; // All fields reset to zero

  // ****************************************************************
  // Conversion timing
  // ****************************************************************
  localparam int unsigned CONV_TIME_US = 282;
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned CONV_CYCLES  = CONV_TIME_US * CLK_MHZ;

endpackage

`default_nettype wire

/* File: verif/uvr_link_model.sv */
/* Link controller model: immediate register reads and writes.
   Assumes strobes are taken on the rising clock edge. */
`timescale 1ns/10ps
`default_nettype none

module uvr_link_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output var  logic       rd_o,
  output var  logic       wr_o,
  output var  logic [5:0] addr_o,
  output var  logic [7:0] wdata_o
);
  // ****************************************************************
  // Register access
  // ****************************************************************
  // Idle bus at time zero
  initial begin
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 6'h00;
    wdata_o = 8'h00;
  end

  // One-cycle strobe from a falling edge, data taken after the answer
  task automatic acc(input logic we, input logic [5:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_i);
    wr_o = we;
    rd_o = !we;
    addr_o = a;
    wdata_o = (a inside {[6'h36:6'h38]}) ? (d & 8'hDF) : d;
    @(negedge clk_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~wdata_o;
    @(negedge clk_i);
    q = rdata_i;
  endtask
endmodule // uvr_link_model

`default_nettype wire

/* File: verif/ulpi_vendor_id_sense_regs_tb_top.sv */
/* Self-checking bench for the vendor register group.
   Assumes the link model and uvr_regs with a short conversion. */
`timescale 1ns/10ps
`default_nettype none

module ulpi_vendor_id_sense_regs_tb_top;
  import uvr_pkg::*;
  localparam int unsigned CC = 20;
  logic       core_clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       rd, wr, alt, hs_on, run, done;
  logic       id_open = 1'b0;
  logic       rise_en = 1'b0;
  logic       fall_en = 1'b0;
  logic       kit_en = 1'b0;
  logic [2:0] meas = 3'h0;
  logic [2:0] code;
  logic [1:0] trim;
  logic [5:0] addr;
  logic [7:0] wd, rdat, q;
  int         errors, samples_checked, cyc, n_irq, n;

  // ****************************************************************
  // Clock, partner and design
  // ****************************************************************
  always #2.5 core_clk_i = ~core_clk_i;

  uvr_link_model u_uvr_link_model (.clk_i(core_clk_i), .rdata_i(rdat),
    .rd_o(rd), .wr_o(wr), .addr_o(addr), .wdata_o(wd));

  uvr_regs #(.CONV_CYC(CC)) u_uvr_regs (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(addr),
    .reg_wdata_i(wd), .id_open_i(id_open), .id_meas_code_i(meas),
    .id_open_rise_enable_i(rise_en), .id_open_fall_enable_i(fall_en),
    .kit_irq_enable_i(kit_en), .reg_rdata_o(rdat), .alt_int_o(alt),
    .hs_tx_trim_o(trim), .headset_mode_on_o(hs_on),
    .id_measure_run_o(run), .id_resistor_code_o(code),
    .id_measure_done_o(done));

  // Interrupt pulse count and hang guard
  always @(posedge core_clk_i) begin
    cyc++;
    if (alt === 1'b1) n_irq++;
    if (cyc == 5000) begin
      errors++;
      conclude();
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic w(input logic [5:0] a, input logic [7:0] d);
    u_uvr_link_model.acc(1'b1, a, d, q);
  endtask

  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    u_uvr_link_model.acc(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask

  task automatic pause;
    repeat (8) @(negedge core_clk_i);
  endtask

  // Wait for conversion end, judge its length and the start bit
  task automatic wait_done;
    n = 0;
    while (done !== 1'b1 && n < 100) begin
      @(negedge core_clk_i);
      n++;
    end
    chk({7'h00, 1'(n >= CC - 4 && n <= CC)}, 8'h01);
    chk({7'h00, run}, 8'h00);
  endtask

  task automatic conclude;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    logic [5:0] al [6] = '{6'h21, 6'h30, 6'h31, 6'h33, 6'h36, 6'h3F};
    foreach (al[i]) rc(al[i], RST_BYTE);
  endtask

  task automatic t_trim;
    for (int i = 0; i < 4; i++) begin
      w(ADDR_TRIM, {1'b1, 2'(i), 5'h1F});
      rc(ADDR_TRIM, {1'b0, 2'(i), 5'h00});
      chk({6'h00, trim}, 8'(i));
    end
  endtask

  task automatic t_headset;
    w(ADDR_HEADSET, 8'hFA);
    rc(ADDR_HEADSET, 8'h0A);
    chk({7'h00, hs_on}, 8'h01);
    w(ADDR_HEADSET, 8'h0B);
    chk({7'h00, hs_on}, 8'h00);
  endtask

  task automatic t_float;
    rise_en = 1'b1;
    id_open = 1'b1;
    pause();
    rc(ADDR_LATCH, 8'h01);
    rc(ADDR_LATCH, 8'h00);
    rise_en = 1'b0;
    id_open = 1'b0;
    pause();
    fall_en = 1'b1;
    id_open = 1'b1;
    pause();
    rc(ADDR_LATCH, 8'h00);
    id_open = 1'b0;
    pause();
    rc(ADDR_LATCH, 8'h01);
    chk(8'(n_irq), 8'h02);
  endtask

  task automatic t_conv;
    meas = RCODE_200K;
    w(ADDR_CONV_WR, 8'h04);
    rc(ADDR_CONV_WR, 8'h04);
    w(ADDR_CONV_SET, 8'h50);
    chk({7'h00, run}, 8'h01);
    wait_done();
    chk({5'h00, code}, 8'h03);
    rc(ADDR_LATCH, 8'h08);
    chk(8'(n_irq), 8'h03);
    rc(ADDR_CONV_SET, 8'h4B);
    chk({7'h00, done}, 8'h00);
    rc(ADDR_CONV_CLR, 8'h43);
    w(ADDR_CONV_CLR, 8'h40);
    rc(ADDR_CONV_WR, 8'h03);
  endtask

  // Twin enable alone raises the event, no enable at all does not
  task automatic t_twin;
    kit_en = 1'b1;
    w(ADDR_CONV_SET, 8'h10);
    chk({7'h00, run}, 8'h01);
    wait_done();
    rc(ADDR_LATCH, 8'h08);
    chk(8'(n_irq), 8'h04);
    rc(ADDR_CONV_CLR, 8'h0B);
    kit_en = 1'b0;
    meas = RCODE_ERROR;
    w(ADDR_CONV_SET, 8'h10);
    wait_done();
    chk({5'h00, code}, {5'h00, RCODE_ERROR});
    rc(ADDR_LATCH, 8'h00);
    chk(8'(n_irq), 8'h04);
  endtask

  // Main sequence
  initial begin
    repeat (3) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    t_reset();
    t_trim();
    t_headset();
    t_float();
    t_conv();
    t_twin();
    conclude();
  end
endmodule // ulpi_vendor_id_sense_regs_tb_top

`default_nettype wire
